// >>> hw/ecc_ctrl.sv
// ECC control register, syndrome read port and correction-done clear strobe
//
// Functional notes
// - Control bit 0 set turns on hardware on-the-fly correction.
// - Bit 0 clear keeps the syndrome in local storage for firmware reads.
// - Shift control bit 1 is ignored while hardware correction is on.
// - Setting bit 1 with correction off advances the syndrome by one byte.
// - Ten syndrome bytes are readable one byte at a time at 72H.
// - Bits 3-2 pick host long ECC length: 32, 88, 56 bits, undefined.
// - Formatter always uses 88-bit ECC; length field affects host long only.
// - External reset sets soft reset bit 5 and buffer register bit 0.
// - Soft reset bit stops the sequencer and resets listed formatter registers.
// - Control register returns to reset state on external reset, and on soft reset except bit 6.
// - Bit 6 picks trigger edge: clear falling, set rising.
// - Bit 6 clears on external reset; a soft reset write loads it from data bit 6.
// - Any write to 72H clears correction-done status; data ignored.
`timescale 1ns/10ps
`default_nettype none
`include "ecc_defs.svh"
module ecc_ctrl #(
	parameter int SYND_BYTES = `ECC_SYND_BYTES
) (
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic NRST_I,
	// Microcontroller register port
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	// ECC datapath
	input wire logic SYND_LOAD_I,
	input wire logic [SYND_BYTES*8-1:0] SYND_DATA_I,
	output logic HW_CORR_EN_O,
	output logic [3:0] LONG_ECC_BYTES_O,
	output logic [3:0] FMT_ECC_BYTES_O,
	output logic CORR_DONE_CLR_O,
	// Formatter sequencer
	input wire logic INDEX_I,
	input wire logic SECTOR_I,
	output logic INDEX_PATH_O,
	output logic SEQ_STOP_O,
	output logic BUF_RST_FLAG_SET_O,
	// Auxiliary trigger
	input wire logic AUX_TRIGGER_INPUT_I,
	output logic AUX_TRIG_O
);
	logic [7:0] ctrl_q;
	logic [7:0] rdata_q;
	logic [3:0] long_bytes_q;
	logic [3:0] fmt_bytes_q;
	logic done_clr_q;
	logic index_path_q;
	logic buf_set_q;
	logic aux_prev_q;
	logic aux_trig_q;
	logic wr_ctrl;
	logic wr_done;
	logic rd_hit;
	logic aux_edge;
	ecc_pkg::ecc_len_t len_sel;

	ecc_synd_if #(.SYND_BYTES(SYND_BYTES)) sif ();

	assign wr_ctrl = WR_I && (ADDR_I == `ECC_ADDR_CTRL);
	assign wr_done = WR_I && (ADDR_I == `ECC_ADDR_DONE_CLR);
	assign rd_hit = RD_I;
	assign len_sel = ecc_pkg::ecc_len_t'(ctrl_q[`ECC_BIT_LEN_HI:`ECC_BIT_LEN_LO]);

	// Control register; a write carrying bit 5 puts every field back to reset
	// except the edge select, which takes bit 6 of the written value
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctrl_q <= `ECC_CTRL_RST;
		end else if (wr_ctrl && WDATA_I[`ECC_BIT_SOFT_RST]) begin
			ctrl_q <= `ECC_CTRL_RST;
			ctrl_q[`ECC_BIT_EDGE] <= WDATA_I[`ECC_BIT_EDGE];
		end else if (wr_ctrl) begin
			ctrl_q <= WDATA_I & `ECC_CTRL_WMASK;
			// Shift request only latched with hardware correction off
			ctrl_q[`ECC_BIT_SHIFT] <= WDATA_I[`ECC_BIT_SHIFT] && !WDATA_I[`ECC_BIT_HW_EN];
		end else if (ctrl_q[`ECC_BIT_SHIFT]) begin
			// Self-clearing once the one-symbol shift has been made
			ctrl_q[`ECC_BIT_SHIFT] <= 1'b0;
		end
	end

	// Syndrome store control
	assign sif.hold = !ctrl_q[`ECC_BIT_HW_EN];
	assign sif.load = SYND_LOAD_I;
	assign sif.load_data = SYND_DATA_I;
	assign sif.shift = ctrl_q[`ECC_BIT_SHIFT] && !ctrl_q[`ECC_BIT_HW_EN];

	ecc_synd #(.SYND_BYTES(SYND_BYTES)) u_synd (
		.clk_i(REF_CLK_I),
		.nrst_i(NRST_I),
		.sif(sif)
	);

	// Registered read data, valid the cycle after the read strobe
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			rdata_q <= 8'h00;
		end else if (rd_hit) begin
			case (ADDR_I)
				`ECC_ADDR_CTRL: rdata_q <= ctrl_q & `ECC_CTRL_WMASK;
				`ECC_ADDR_SYND: rdata_q <= sif.sym;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// Host long transfer length; the formatter stays on 88 bits regardless
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			long_bytes_q <= `ECC_LONG_BYTES_32;
		end else begin
			case (len_sel)
				ecc_pkg::ECC_LEN_32: long_bytes_q <= `ECC_LONG_BYTES_32;
				ecc_pkg::ECC_LEN_88: long_bytes_q <= `ECC_LONG_BYTES_88;
				ecc_pkg::ECC_LEN_56: long_bytes_q <= `ECC_LONG_BYTES_56;
				default: long_bytes_q <= `ECC_LONG_BYTES_UNDEF;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			fmt_bytes_q <= `ECC_FMT_BYTES;
		end else begin
			fmt_bytes_q <= `ECC_FMT_BYTES;
		end
	end

	// Correction-done clear strobe; written value is don't care
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			done_clr_q <= 1'b0;
		end else begin
			done_clr_q <= wr_done;
		end
	end

	// Index path merge
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			index_path_q <= 1'b0;
		end else begin
			index_path_q <= INDEX_I || (ctrl_q[`ECC_BIT_MERGE] && SECTOR_I);
		end
	end

	// Buffer-side flag set: high through reset, cleared on the first clock edge after release
	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			buf_set_q <= 1'b1;
		end else begin
			buf_set_q <= 1'b0;
		end
	end

	// Auxiliary trigger edge detect; previous level starts low, which is safe
	// because the pin reset always leaves falling-edge mode selected
	assign aux_edge = ctrl_q[`ECC_BIT_EDGE] ? (AUX_TRIGGER_INPUT_I && !aux_prev_q)
		: (!AUX_TRIGGER_INPUT_I && aux_prev_q);

	always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			aux_prev_q <= 1'b0;
			aux_trig_q <= 1'b0;
		end else begin
			aux_prev_q <= AUX_TRIGGER_INPUT_I;
			aux_trig_q <= aux_edge;
		end
	end

	assign RDATA_O = rdata_q;
	assign HW_CORR_EN_O = ctrl_q[`ECC_BIT_HW_EN];
	assign LONG_ECC_BYTES_O = long_bytes_q;
	assign FMT_ECC_BYTES_O = fmt_bytes_q;
	assign CORR_DONE_CLR_O = done_clr_q;
	assign INDEX_PATH_O = index_path_q;
	assign SEQ_STOP_O = ctrl_q[`ECC_BIT_SOFT_RST];
	assign BUF_RST_FLAG_SET_O = buf_set_q;
	assign AUX_TRIG_O = aux_trig_q;

	soft_reset_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(wr_ctrl && WDATA_I[`ECC_BIT_SOFT_RST]) |=>
		((ctrl_q & 8'hBF) == `ECC_CTRL_RST) && SEQ_STOP_O)
		else $error("soft reset did not restore control register");
	edge_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(wr_ctrl && WDATA_I[`ECC_BIT_SOFT_RST]) |=>
		(ctrl_q[`ECC_BIT_EDGE] == $past(WDATA_I[`ECC_BIT_EDGE])))
		else $error("edge select altered by soft reset");
	shift_ignore_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		ctrl_q[`ECC_BIT_HW_EN] |-> !sif.shift)
		else $error("syndrome shifted with hardware correction on");
	shift_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(ctrl_q[`ECC_BIT_SHIFT] && !wr_ctrl) |=> !ctrl_q[`ECC_BIT_SHIFT])
		else $error("shift bit not self-cleared");
	long_len_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(len_sel == ecc_pkg::ECC_LEN_56) |=> (LONG_ECC_BYTES_O == `ECC_LONG_BYTES_56))
		else $error("long length 56-bit not selected");
	fmt_fixed_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		FMT_ECC_BYTES_O == `ECC_FMT_BYTES)
		else $error("formatter ECC length not 88 bits");
	done_clr_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		wr_done |=> CORR_DONE_CLR_O ##1 !CORR_DONE_CLR_O || $past(wr_done))
		else $error("correction-done clear strobe wrong");
	merge_path_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(ctrl_q[`ECC_BIT_MERGE] && SECTOR_I) |=> INDEX_PATH_O)
		else $error("sector pulse not merged onto index path");
	rsvd_zero_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(rd_hit && ADDR_I == `ECC_ADDR_CTRL) |=> !RDATA_O[`ECC_BIT_RSVD])
		else $error("reserved bit read as one");
	edge_rise_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(ctrl_q[`ECC_BIT_EDGE] && $rose(AUX_TRIGGER_INPUT_I)) |=> AUX_TRIG_O)
		else $error("rising edge trigger missed");
	edge_fall_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(!ctrl_q[`ECC_BIT_EDGE] && $past(NRST_I) && $fell(AUX_TRIGGER_INPUT_I)) |=> AUX_TRIG_O)
		else $error("falling edge trigger missed");
	synd_read_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		(rd_hit && ADDR_I == `ECC_ADDR_SYND) |=> (RDATA_O == $past(sif.sym)))
		else $error("syndrome byte not returned on read");
	buf_flag_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		$past(NRST_I) |-> !BUF_RST_FLAG_SET_O)
		else $error("buffer reset flag held after reset release");
	done_quiet_a: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
		!wr_done |=> !CORR_DONE_CLR_O)
		else $error("correction-done clear strobe without write");
endmodule
`default_nettype wire

// >>> hw/ecc_defs.svh
// Offsets, field positions, reset values and counts of the ECC control block
`ifndef ECC_DEFS_SVH
`define ECC_DEFS_SVH

`define ECC_ADDR_CTRL 8'h71
`define ECC_ADDR_SYND 8'h72
`define ECC_ADDR_DONE_CLR 8'h72

`define ECC_BIT_HW_EN 0
`define ECC_BIT_SHIFT 1
`define ECC_BIT_LEN_LO 2
`define ECC_BIT_LEN_HI 3
`define ECC_BIT_MERGE 4
`define ECC_BIT_SOFT_RST 5
`define ECC_BIT_EDGE 6
`define ECC_BIT_RSVD 7

`define ECC_CTRL_RST 8'h20
`define ECC_CTRL_WMASK 8'h7F

`define ECC_SYND_BYTES 10
`define ECC_SYM_BITS 8

`define ECC_LONG_BYTES_32 4'h4
`define ECC_LONG_BYTES_88 4'hB
`define ECC_LONG_BYTES_56 4'h7
`define ECC_LONG_BYTES_UNDEF 4'h0
`define ECC_FMT_BYTES 4'hB

`endif

// >>> hw/ecc_pkg.sv
// Types shared by the ECC control block
package ecc_pkg;
	typedef enum logic [1:0] {
		ECC_LEN_32 = 2'b00,
		ECC_LEN_88 = 2'b01,
		ECC_LEN_56 = 2'b10,
		ECC_LEN_UNDEF = 2'b11
	} ecc_len_t;
endpackage

// >>> hw/ecc_synd_if.sv
// Carrier between the control register logic and the syndrome store
`timescale 1ns/10ps
`default_nettype none
interface ecc_synd_if #(parameter int SYND_BYTES = 10);
	logic load;
	logic [SYND_BYTES*8-1:0] load_data;
	logic shift;
	logic hold;
	logic [7:0] sym;
	modport ctrl (output load, output load_data, output shift, output hold, input sym);
	modport store (input load, input load_data, input shift, input hold, output sym);
endinterface
`default_nettype wire

// >>> hw/ecc_synd.sv
// Syndrome store read by firmware one symbol at a time
`timescale 1ns/10ps
`default_nettype none
`include "ecc_defs.svh"
module ecc_synd #(
	parameter int SYND_BYTES = `ECC_SYND_BYTES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Link to control logic
	ecc_synd_if.store sif
);
	logic [SYND_BYTES*8-1:0] synd_q;

	// Only the external reset clears the store; the soft reset leaves it
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			synd_q <= '0;
		end else if (sif.load && sif.hold) begin
			synd_q <= sif.load_data;
		end else if (sif.shift) begin
			synd_q <= {8'h00, synd_q[SYND_BYTES*8-1:8]};
		end
	end

	assign sif.sym = synd_q[7:0];

	shift_step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(sif.shift && !(sif.load && sif.hold)) |=> (sif.sym == $past(synd_q[15:8])))
		else $error("syndrome did not advance one symbol");
	keep_synd_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(sif.load && sif.hold) |=> (synd_q == $past(sif.load_data)))
		else $error("syndrome not captured while correction disabled");
endmodule
`default_nettype wire

// >>> dv/ecc_mcu_model.sv
// Microcontroller model that drives the ECC control register port
`timescale 1ns/10ps
`default_nettype none
module ecc_mcu_model (
	// Clock
	input wire logic clk_i,
	// Register port
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Released lines show the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
	// Callers read syndrome bytes only with correction off, stepping by the shift bit
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
		addr_o = ~a;
	endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the ECC control register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr, wdata, rdata, rv;
	logic wr, rd, synd_load = 1'b0, index = 1'b0, sector = 1'b0, aux = 1'b0;
	logic [79:0] synd_data = 80'hAA998877665544332211;
	logic hw_en, clr, ipath, stop, bufset, trig;
	logic [3:0] long_b, fmt_b;
	logic [3:0] len_tab [4] = '{4'h4, 4'hB, 4'h7, 4'h0};
	int failures = 0, samples_checked = 0, cyc = 0;
	always #50 clk = ~clk;
	ecc_mcu_model ecc_mcu_model_i (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));
	ecc_ctrl ecc_ctrl_i (.REF_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SYND_LOAD_I(synd_load),
		.SYND_DATA_I(synd_data), .HW_CORR_EN_O(hw_en), .LONG_ECC_BYTES_O(long_b),
		.FMT_ECC_BYTES_O(fmt_b), .CORR_DONE_CLR_O(clr), .INDEX_I(index), .SECTOR_I(sector),
		.INDEX_PATH_O(ipath), .SEQ_STOP_O(stop), .BUF_RST_FLAG_SET_O(bufset),
		.AUX_TRIGGER_INPUT_I(aux), .AUX_TRIG_O(trig));
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		ecc_mcu_model_i.rd(a, rv);
		chk(rv, e);
	endtask
	// Counts trigger pulses after the input settles at lvl
	task automatic edge_chk(input logic lvl, input logic [7:0] n);
		int cnt;
		cnt = 0;
		@(negedge clk);
		aux = ~lvl;
		repeat (3) @(negedge clk);
		aux = lvl;
		repeat (4) begin
			@(negedge clk);
			if (trig === 1'b1) cnt++;
		end
		chk(cnt[7:0], n);
	endtask
	// Ceiling sits far above the roughly 150 cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		chk({7'h0, bufset}, 8'h01);
		nrst = 1'b1;
		@(negedge clk);
		chk({7'h0, bufset}, 8'h00);
		rchk(8'h71, 8'h20);
		chk({7'h0, stop}, 8'h01);
		chk({4'h0, fmt_b}, 8'h0B);
		rchk(8'h70, 8'h00);
		ecc_mcu_model_i.wr(8'h71, 8'hFF);
		rchk(8'h71, 8'h60);
		ecc_mcu_model_i.wr(8'h71, 8'h40);
		rchk(8'h71, 8'h40);
		chk({7'h0, stop}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			ecc_mcu_model_i.wr(8'h71, 8'(i << 2));
			@(negedge clk);
			chk({4'h0, long_b}, {4'h0, len_tab[i]});
			chk({4'h0, fmt_b}, 8'h0B);
		end
		@(negedge clk);
		synd_load = 1'b1;
		@(negedge clk);
		synd_load = 1'b0;
		ecc_mcu_model_i.wr(8'h71, 8'h03);
		chk({7'h0, hw_en}, 8'h01);
		rchk(8'h71, 8'h01);
		ecc_mcu_model_i.wr(8'h71, 8'h00);
		for (int i = 0; i < 10; i++) begin
			rchk(8'h72, 8'(8'h11 * (i + 1)));
			ecc_mcu_model_i.wr(8'h71, 8'h02);
		end
		rchk(8'h72, 8'h00);
		ecc_mcu_model_i.wr(8'h71, 8'h01);
		synd_load = 1'b1;
		@(negedge clk);
		synd_load = 1'b0;
		ecc_mcu_model_i.wr(8'h71, 8'h00);
		rchk(8'h72, 8'h00);
		ecc_mcu_model_i.wr(8'h72, 8'h00);
		chk({7'h0, clr}, 8'h01);
		@(negedge clk);
		chk({7'h0, clr}, 8'h00);
		sector = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h0, ipath}, 8'h00);
		ecc_mcu_model_i.wr(8'h71, 8'h10);
		@(negedge clk);
		chk({7'h0, ipath}, 8'h01);
		sector = 1'b0;
		index = 1'b1;
		repeat (2) @(negedge clk);
		chk({7'h0, ipath}, 8'h01);
		index = 1'b0;
		edge_chk(1'b0, 8'h01);
		edge_chk(1'b1, 8'h00);
		ecc_mcu_model_i.wr(8'h71, 8'h40);
		edge_chk(1'b1, 8'h01);
		edge_chk(1'b0, 8'h00);
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		chk({7'h0, bufset}, 8'h01);
		nrst = 1'b1;
		rchk(8'h71, 8'h20);
		final_report();
	end
endmodule
`default_nettype wire
